// [pkg/qrw_pkg.sv]
// Purpose: constants and types for the quad i/o read sequencer
// Assumes: spi mode 0, serial clock at most one quarter of the system clock
// Notes: opcodes go in on quad_data_lines[0]; everything after goes on all four lines
package qrw_pkg;
  localparam int ADDR_W = 24;
  localparam logic [7:0] OP_QUAD_READ = 8'heb;
  localparam logic [7:0] OP_WORD_READ = 8'he7;
  localparam logic [7:0] OP_OCTAL_READ = 8'he3;
  localparam logic [7:0] OP_WRAP_SETUP = 8'h77;
  localparam logic [4:0] OPCODE_CLKS = 5'h08;
  localparam logic [4:0] ADDR_CLKS = 5'h06;
  localparam logic [4:0] MODE_CLKS = 5'h02;
  localparam logic [4:0] WRAP_SETUP_CLKS = 5'h08;
  localparam logic [4:0] DUMMY_QUAD = 5'h04;
  localparam logic [4:0] DUMMY_WORD = 5'h02;
  localparam logic [4:0] DUMMY_OCTAL = 5'h00;
  localparam logic [1:0] CONT_KEEP = 2'h2;
  localparam int CONT_SEL_POS = 4;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_POS = 5;
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  localparam logic [23:0] WORD_ALIGN_MASK = 24'hfffffe;
  localparam logic [23:0] OCTAL_ALIGN_MASK = 24'hfffff0;
  localparam logic [4:0] RESET_MIN_NIBBLES = 5'h02;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h3,
    ST_MODE = 3'h2,
    ST_DUMMY = 3'h6,
    ST_DATA = 3'h7,
    ST_WRAPSET = 3'h5,
    ST_IGNORE = 3'h4
  } qrw_state_t;

  typedef enum logic [1:0] {
    CMD_QUAD = 2'h0,
    CMD_WORD = 2'h1,
    CMD_OCTAL = 2'h2
  } qrw_cmd_t;

  // section mask for a wrap length code: 8 << len, minus one
  function automatic logic [23:0] qrw_wrap_mask(input logic [1:0] len);
    qrw_wrap_mask = (24'h000008 << len) - 24'h000001;
  endfunction
endpackage

// [pkg/qrw_addr_if.sv]
`timescale 1ns/1ps
// Purpose: carries the read address controls between sequencer and address counter
// Assumes: single system clock
// Notes: load and advance are one-cycle pulses
interface qrw_addr_if;
  logic load;
  logic [23:0] load_addr;
  logic advance;
  logic wrap_en;
  logic [1:0] wrap_len;
  logic [23:0] addr;
  modport ctrl (output load, output load_addr, output advance, output wrap_en,
    output wrap_len, input addr);
  modport cnt (input load, input load_addr, input advance, input wrap_en,
    input wrap_len, output addr);
endinterface

// [hdl/qrw_addr_gen.sv]
`timescale 1ns/1ps
// Purpose: read address counter with section wrap
// Assumes: advance only while a read streams
// Notes: address held in a flip-flop, drives the memory port directly
module qrw_addr_gen
  import qrw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  qrw_addr_if.cnt ai
);
  logic [23:0] addr_r;
  logic [23:0] mask;
  logic [23:0] addr_nxt;

  assign mask = qrw_wrap_mask(ai.wrap_len);
  assign ai.addr = addr_r;

  always_comb
  begin
    if (ai.wrap_en)
      addr_nxt = (addr_r & ~mask) | ((addr_r + 24'h000001) & mask);
    else
      addr_nxt = addr_r + 24'h000001;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      addr_r <= '0;
    else if (ai.load)
      addr_r <= ai.load_addr;
    else if (ai.advance)
      addr_r <= addr_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_wrap_in_section: assert property (ai.advance && !ai.load && ai.wrap_en |=>
    ((addr_r & ~mask) == ($past(addr_r) & ~mask)))
    else $error("wrap burst left its section");
  a_wrap_to_base: assert property (ai.advance && !ai.load && ai.wrap_en &&
    ((addr_r & mask) == mask) |=> ((addr_r & mask) == 24'h000000))
    else $error("wrap did not return to section base");
  a_linear_step: assert property (ai.advance && !ai.load && !ai.wrap_en |=>
    addr_r == $past(addr_r) + 24'h000001)
    else $error("linear read did not step by one");
endmodule // qrw_addr_gen

// [hdl/qrw_quad_read.sv]
`timescale 1ns/1ps
// Purpose: quad i/o read sequencer with wrap setup and continuous mode
// Assumes: pins synchronous to clock; serial clock at most clock/4
// Notes: memory answers mem_rdata one clock after mem_addr changes
module qrw_quad_read
  import qrw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic [3:0] quad_data_lines_in,
  output logic [3:0] quad_data_lines_out,
  output logic [3:0] quad_data_lines_oe,
  input wire logic quad_lines_enable_bit,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic wrap_disable_bit,
  output logic [1:0] wrap_length_select,
  output logic continuous_active
);
  qrw_state_t state_r;
  qrw_cmd_t cmd_r;
  qrw_cmd_t cont_cmd_r;
  logic [4:0] cnt_r;
  logic [7:0] op_r;
  logic [7:0] op_nxt;
  logic [19:0] addr_sh_r;
  logic [23:0] addr_full;
  logic [3:0] mode_hi_r;
  logic [7:0] wrap_byte_nxt;
  logic [4:0] dummy_need;
  logic sclk_q_r;
  logic cs_q_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic phase_r;
  logic [3:0] lo_r;
  logic ones_r;
  logic mode_done;
  logic ff_reset;
  logic [3:0] io_out_r;
  logic io_oe_r;
  logic wrap_dis_r;
  logic [1:0] wrap_len_r;
  logic cont_r;

  qrw_addr_if ai ();

  qrw_addr_gen u_addr (
    .clock(clock),
    .sys_rst(sys_rst),
    .ai(ai.cnt)
  );

  assign sclk_rise = serial_clk & ~sclk_q_r;
  assign sclk_fall = ~serial_clk & sclk_q_r;
  assign cs_rise = chip_sel_n & ~cs_q_r;
  assign op_nxt = {op_r[6:0], quad_data_lines_in[0]};
  assign addr_full = {addr_sh_r, quad_data_lines_in};
  assign wrap_byte_nxt = {mode_hi_r, quad_data_lines_in};
  assign mode_done = sclk_rise && state_r == ST_MODE && cnt_r == MODE_CLKS - 5'h01;
  assign ff_reset = cs_rise && cont_r && state_r == ST_ADDR && ones_r &&
    cnt_r >= RESET_MIN_NIBBLES;

  always_comb
  begin
    unique case (cmd_r)
      CMD_WORD: dummy_need = DUMMY_WORD;
      CMD_OCTAL: dummy_need = DUMMY_OCTAL;
      default: dummy_need = DUMMY_QUAD;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end
    else
    begin
      sclk_q_r <= serial_clk;
      cs_q_r <= chip_sel_n;
    end
  end

  // command framing
  always_ff @(posedge clock)
  begin
    if (sys_rst || chip_sel_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else if (state_r == ST_IDLE)
    begin
      state_r <= cont_r ? ST_ADDR : ST_OPCODE;
      cnt_r <= '0;
    end
    else if (sclk_rise)
    begin
      cnt_r <= cnt_r + 5'h01;
      unique case (state_r)
        ST_OPCODE:
          if (cnt_r == OPCODE_CLKS - 5'h01)
          begin
            cnt_r <= '0;
            if (op_nxt == OP_WRAP_SETUP)
              state_r <= ST_WRAPSET;
            else if ((op_nxt == OP_QUAD_READ || op_nxt == OP_WORD_READ ||
                op_nxt == OP_OCTAL_READ) && quad_lines_enable_bit)
              state_r <= ST_ADDR;
            else
              state_r <= ST_IGNORE;
          end
        ST_ADDR:
          if (cnt_r == ADDR_CLKS - 5'h01)
          begin
            cnt_r <= '0;
            state_r <= ST_MODE;
          end
        ST_MODE:
          if (cnt_r == MODE_CLKS - 5'h01)
          begin
            cnt_r <= '0;
            state_r <= (dummy_need == 5'h00) ? ST_DATA : ST_DUMMY;
          end
        ST_DUMMY:
          if (cnt_r == dummy_need - 5'h01)
          begin
            cnt_r <= '0;
            state_r <= ST_DATA;
          end
        ST_WRAPSET:
          if (cnt_r == WRAP_SETUP_CLKS - 5'h01)
            state_r <= ST_IGNORE;
        ST_DATA, ST_IGNORE, ST_IDLE:
          cnt_r <= cnt_r;
      endcase
    end
  end

  // shift registers and command type
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      op_r <= '0;
      addr_sh_r <= '0;
      mode_hi_r <= '0;
      cmd_r <= CMD_QUAD;
      ones_r <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      cmd_r <= cont_cmd_r;
      ones_r <= 1'b1;
    end
    else if (sclk_rise)
    begin
      op_r <= op_nxt;
      addr_sh_r <= addr_full[19:0];
      mode_hi_r <= quad_data_lines_in;
      if (state_r == ST_ADDR)
        ones_r <= ones_r & (quad_data_lines_in == 4'hf);
      if (state_r == ST_OPCODE && cnt_r == OPCODE_CLKS - 5'h01)
        cmd_r <= (op_nxt == OP_WORD_READ) ? CMD_WORD :
          (op_nxt == OP_OCTAL_READ) ? CMD_OCTAL : CMD_QUAD;
    end
  end

  // wrap configuration
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrap_dis_r <= WRAP_DIS_RST;
      wrap_len_r <= WRAP_LEN_RST;
    end
    else if (sclk_rise && state_r == ST_WRAPSET && cnt_r == WRAP_SETUP_CLKS - 5'h01)
    begin
      wrap_dis_r <= wrap_byte_nxt[WRAP_DIS_POS];
      wrap_len_r <= wrap_byte_nxt[WRAP_LEN_POS +: 2];
    end
  end

  // continuous mode; only the select bits matter
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cont_r <= 1'b0;
      cont_cmd_r <= CMD_QUAD;
    end
    else if (mode_done)
    begin
      cont_r <= (mode_hi_r[CONT_SEL_POS - 4 +: 2] == CONT_KEEP);
      cont_cmd_r <= cmd_r;
    end
    else if (ff_reset)
      cont_r <= 1'b0;
  end

  // address load and nibble output
  always_comb
  begin
    ai.load = sclk_rise && state_r == ST_ADDR && cnt_r == ADDR_CLKS - 5'h01;
    unique case (cmd_r)
      CMD_WORD: ai.load_addr = addr_full & WORD_ALIGN_MASK;
      CMD_OCTAL: ai.load_addr = addr_full & OCTAL_ALIGN_MASK;
      default: ai.load_addr = addr_full;
    endcase
    ai.advance = sclk_fall && state_r == ST_DATA && !phase_r;
    ai.wrap_en = !wrap_dis_r && cmd_r != CMD_OCTAL;
    ai.wrap_len = wrap_len_r;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || chip_sel_n)
    begin
      io_out_r <= '0;
      io_oe_r <= 1'b0;
      phase_r <= 1'b0;
      lo_r <= '0;
    end
    else if (sclk_fall && state_r == ST_DATA)
    begin
      io_oe_r <= 1'b1;
      phase_r <= ~phase_r;
      if (!phase_r)
      begin
        io_out_r <= mem_rdata[7:4];
        lo_r <= mem_rdata[3:0];
      end
      else
        io_out_r <= lo_r;
    end
  end

  assign quad_data_lines_out = io_out_r;
  assign quad_data_lines_oe = {4{io_oe_r}};
  assign mem_addr = ai.addr;
  assign wrap_disable_bit = wrap_dis_r;
  assign wrap_length_select = wrap_len_r;
  assign continuous_active = cont_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_frame_start;
    state_r == ST_IDLE && !chip_sel_n;
  endsequence
  sequence s_opcode_end;
    sclk_rise && state_r == ST_OPCODE && cnt_r == OPCODE_CLKS - 5'h01;
  endsequence

  a_cont_skip_opcode: assert property (s_frame_start and cont_r |=> state_r == ST_ADDR)
    else $error("continuous frame did not start at address");
  a_normal_opcode: assert property (s_frame_start and !cont_r |=> state_r == ST_OPCODE)
    else $error("normal frame did not expect opcode");
  a_word_refused: assert property (s_opcode_end and op_nxt == OP_WORD_READ &&
    !quad_lines_enable_bit |=> state_r == ST_IGNORE)
    else $error("word read accepted with quad lines off");
  a_octal_refused: assert property (s_opcode_end and op_nxt == OP_OCTAL_READ &&
    !quad_lines_enable_bit |=> state_r == ST_IGNORE)
    else $error("octal read accepted with quad lines off");
  a_dummy_bound: assert property (state_r == ST_DUMMY |-> cnt_r < dummy_need &&
    cmd_r != CMD_OCTAL)
    else $error("dummy phase overran its count");
  a_mode_latch: assert property (mode_done && !chip_sel_n |=>
    cont_r == ($past(mode_hi_r[1:0]) == CONT_KEEP))
    else $error("select bits not latched");
  a_ones_reset: assert property (ff_reset |=> !cont_r)
    else $error("all-ones reset left continuous mode on");
  a_wrap_default: assert property ($fell(sys_rst) |-> wrap_dis_r && wrap_len_r == 2'h0)
    else $error("wrap bits wrong after reset");
  a_quiet_before_data: assert property (state_r != ST_DATA |-> !io_oe_r)
    else $error("lines driven outside data phase");
endmodule // qrw_quad_read

// [verification/qrw_host_model.sv]
// Purpose: host controller model for the quad read link
// Assumes: serial clock low for four and high for two system clocks
// Notes: lines the host has released show an inverted pattern
`timescale 1ns/1ps
module qrw_host_model (
  input wire logic clock,
  input wire logic [3:0] quad_data_lines_out,
  input wire logic [3:0] quad_data_lines_oe,
  output logic chip_sel_n,
  output logic serial_clk,
  output logic [3:0] host_drv,
  output logic host_oe
);
  logic [7:0] got [80];
  logic oe_seen;
  logic [3:0] rv;

  initial
  begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    host_drv = 4'h0;
    host_oe = 1'b0;
    oe_seen = 1'b0;
    rv = 4'h0;
  end

  // one serial clock: fall, drive, sample device nibble, rise
  task automatic tick(input logic [3:0] nib, input logic drv);
    @(posedge clock);
    serial_clk <= 1'b0;
    host_drv <= drv ? nib : ~host_drv;
    host_oe <= drv;
    repeat (3) @(posedge clock);
    #1;
    rv = quad_data_lines_out;
    if (quad_data_lines_oe !== 4'h0)
      oe_seen = 1'b1;
    @(posedge clock);
    serial_clk <= 1'b1;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] op, input logic op_on, input logic [23:0] a,
    input logic [7:0] m, input int dum, input int nb);
    int i;
    oe_seen = 1'b0;
    @(posedge clock);
    chip_sel_n <= 1'b0;
    if (op_on)
      for (i = 7; i >= 0; i--)
        tick({3'h0, op[i]}, 1'b1);
    for (i = 5; i >= 0; i--)
      tick(a[i*4 +: 4], 1'b1);
    tick(m[7:4], 1'b1);
    tick(m[3:0], 1'b1);
    for (i = 0; i < dum; i++)
      tick(4'h0, 1'b0);
    for (i = 0; i < 2 * nb; i++)
    begin
      tick(4'h0, 1'b0);
      got[i/2] = {got[i/2][3:0], rv};
    end
    @(posedge clock);
    serial_clk <= 1'b0;
    chip_sel_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // frame cut short after n all-ones nibbles
  task automatic cut(input int n);
    int i;
    @(posedge clock);
    chip_sel_n <= 1'b0;
    for (i = 0; i < n; i++)
      tick(4'hf, 1'b1);
    @(posedge clock);
    serial_clk <= 1'b0;
    chip_sel_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule // qrw_host_model

// [verification/qrw_quad_read_tb.sv]
// Purpose: self-checking bench for the quad read sequencer
// Assumes: memory byte is low address byte xor middle address byte
// Notes: host model drives the link, bench models the memory
`timescale 1ns/1ps
module qrw_quad_read_tb
  import qrw_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic qe = 1'b1;
  logic chip_sel_n, serial_clk, host_oe;
  logic [3:0] host_drv, lines, dout, doe;
  logic [23:0] mem_addr;
  logic [7:0] mem_rdata;
  logic wrap_dis, cont;
  logic [1:0] wrap_len;
  int mismatches = 0;
  int checks_done = 0;

  assign lines = host_oe ? host_drv : (doe[0] ? dout : host_drv);

  qrw_quad_read qrw_quad_read_inst (.clock(clock), .sys_rst(sys_rst),
    .chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .quad_data_lines_in(lines),
    .quad_data_lines_out(dout), .quad_data_lines_oe(doe), .quad_lines_enable_bit(qe),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .wrap_disable_bit(wrap_dis),
    .wrap_length_select(wrap_len), .continuous_active(cont));

  qrw_host_model qrw_host_model_inst (.clock(clock), .quad_data_lines_out(dout),
    .quad_data_lines_oe(doe), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .host_drv(host_drv), .host_oe(host_oe));

  initial
  begin
    forever #5 clock = ~clock;
  end

  always_ff @(posedge clock)
    mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8];

  task automatic check(input logic [23:0] g, input logic [23:0] e, input string what);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic chk_bytes(input logic [23:0] a0, input int nb, input logic [23:0] mk);
    int i;
    logic [23:0] a;
    for (i = 0; i < nb; i++)
    begin
      a = (a0 & ~mk) | ((a0 + i) & mk);
      check({16'h0, qrw_host_model_inst.got[i]}, {16'h0, a[7:0] ^ a[15:8]}, "data byte");
    end
  endtask

  task automatic rd(input logic [7:0] op, input logic on, input logic [23:0] a,
    input logic [7:0] m, input int dum, input int nb);
    qrw_host_model_inst.rd(op, on, a, m, dum, nb);
  endtask

  task automatic t_reset;
    check({23'h0, wrap_dis}, 24'h1, "wrap disable");
    check({22'h0, wrap_len}, 24'h0, "wrap length");
    check({23'h0, cont}, 24'h0, "continuous");
    check({20'h0, doe}, 24'h0, "output enable");
  endtask

  task automatic t_plain;
    rd(OP_QUAD_READ, 1'b1, 24'h0123fd, 8'h00, 4, 6);
    chk_bytes(24'h0123fd, 6, 24'hffffff);
    check({23'h0, cont}, 24'h0, "continuous");
  endtask

  task automatic t_wrap;
    int len;
    for (len = 0; len < 4; len++)
    begin
      rd(OP_WRAP_SETUP, 1'b1, 24'h0, {1'b0, len[1:0], 5'h00}, 0, 0);
      check({23'h0, wrap_dis}, 24'h0, "wrap disable");
      check({22'h0, wrap_len}, {22'h0, len[1:0]}, "wrap length");
      rd(len[0] ? OP_WORD_READ : OP_QUAD_READ, 1'b1, 24'h123476, 8'h00, len[0] ? 2 : 4,
        (8 << len) + 2);
      chk_bytes(24'h123476, (8 << len) + 2, (24'h000008 << len) - 24'h1);
    end
    rd(OP_OCTAL_READ, 1'b1, 24'h123470, 8'h00, 0, 20);
    chk_bytes(24'h123470, 20, 24'hffffff);
    rd(OP_WRAP_SETUP, 1'b1, 24'h0, 8'h10, 0, 0);
    check({23'h0, wrap_dis}, 24'h1, "wrap disable");
  endtask

  task automatic t_align;
    rd(OP_WORD_READ, 1'b1, 24'h000201, 8'h00, 2, 4);
    chk_bytes(24'h000200, 4, 24'hffffff);
    rd(OP_OCTAL_READ, 1'b1, 24'h00030b, 8'h00, 0, 4);
    chk_bytes(24'h000300, 4, 24'hffffff);
  endtask

  task automatic t_cont;
    int k;
    logic [7:0] op;
    for (k = 0; k < 3; k++)
    begin
      op = k == 0 ? OP_QUAD_READ : (k == 1 ? OP_WORD_READ : OP_OCTAL_READ);
      rd(op, 1'b1, 24'h004410, 8'ha5, 4 - 2 * k, 2);
      check({23'h0, cont}, 24'h1, "continuous");
      rd(op, 1'b0, 24'h004520, 8'h0f, 4 - 2 * k, 3);
      chk_bytes(24'h004520, 3, 24'hffffff);
      check({23'h0, cont}, 24'h0, "continuous");
    end
  endtask

  task automatic t_ffrst;
    rd(OP_QUAD_READ, 1'b1, 24'h000050, 8'h20, 4, 1);
    check({23'h0, cont}, 24'h1, "continuous");
    rd(8'h00, 1'b0, 24'hffffff, 8'hff, 0, 0);
    check({23'h0, cont}, 24'h0, "continuous");
    rd(OP_QUAD_READ, 1'b1, 24'h000050, 8'h20, 4, 1);
    check({23'h0, cont}, 24'h1, "continuous");
    qrw_host_model_inst.cut(4);
    check({23'h0, cont}, 24'h0, "continuous");
    rd(OP_QUAD_READ, 1'b1, 24'h000060, 8'h00, 4, 2);
    chk_bytes(24'h000060, 2, 24'hffffff);
  endtask

  task automatic t_refuse;
    int k;
    @(posedge clock);
    qe <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      rd(k == 0 ? OP_QUAD_READ : (k == 1 ? OP_WORD_READ : OP_OCTAL_READ), 1'b1,
        24'h000100, 8'h20, 4 - 2 * k, 2);
      check({23'h0, qrw_host_model_inst.oe_seen}, 24'h0, "refused drive");
      check({23'h0, cont}, 24'h0, "refused mode");
    end
    @(posedge clock);
    qe <= 1'b1;
    rd(8'h5a, 1'b1, 24'h000100, 8'h20, 4, 2);
    check({23'h0, qrw_host_model_inst.oe_seen}, 24'h0, "unknown drive");
    check({23'h0, cont}, 24'h0, "unknown mode");
  endtask

  task automatic complete_run;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_plain();
    t_wrap();
    t_align();
    t_cont();
    t_ffrst();
    t_refuse();
    complete_run();
  end
endmodule // qrw_quad_read_tb
